// File: core/xcvr_pkg.sv
// Shared constants and types for the transceiver mode and data link ends
package xcvr_pkg;
    // ------------------------------------------------------------
    // Mode pin codes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_SLEEP    = 3'h0;
    localparam logic [2:0] MODE_STANDBY  = 3'h1;
    localparam logic [2:0] MODE_RX_BB    = 3'h2;
    localparam logic [2:0] MODE_RX_SYNTH = 3'h3;
    localparam logic [2:0] MODE_RX       = 3'h4;
    localparam logic [2:0] MODE_TX_SYNTH = 3'h6;
    localparam logic [2:0] MODE_TX       = 3'h7;

    // ------------------------------------------------------------
    // Device configuration word fields
    // ------------------------------------------------------------
    localparam int unsigned CFG_W        = 7;
    localparam int unsigned CFG_BITSYNC  = 0;
    localparam int unsigned CFG_PAT_EN   = 1;
    localparam int unsigned CFG_CLKO_EN  = 2;
    localparam int unsigned CFG_CLKSEL   = 3;
    localparam int unsigned CFG_PATLEN   = 5;
    localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;
    localparam logic [31:0]      PAT_RESET = 32'h0000_0000;
    localparam int unsigned BIT_CYCLES_DEF = 64;

    // ------------------------------------------------------------
    // Timing of the mode strobe
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ       = 200;
    localparam int unsigned STROBE_LOW_NS = 2000;
    localparam int unsigned MODE_HOLD_NS  = 200;
    localparam int unsigned STROBE_LOW_CYC = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned MODE_HOLD_CYC  = (MODE_HOLD_NS * CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------
    // Host register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_W_OS   = 8'h04;
    localparam logic [7:0] REG_W_BBR  = 8'h08;
    localparam logic [7:0] REG_W_FS   = 8'h0C;
    localparam logic [7:0] REG_W_BB2  = 8'h10;
    localparam logic [7:0] REG_W_TR   = 8'h14;
    localparam logic [7:0] REG_BITDIV = 8'h18;
    localparam logic [7:0] REG_TXDATA = 8'h1C;
    localparam logic [7:0] REG_STATUS = 8'h20;
    localparam int unsigned CTRL_GO_RX    = 0;
    localparam int unsigned CTRL_GO_TX    = 1;
    localparam int unsigned CTRL_GO_STBY  = 2;
    localparam int unsigned CTRL_GO_SLEEP = 3;
    localparam int unsigned WAIT_W = 24;
    localparam logic [WAIT_W-1:0] WAIT_RESET   = 24'h000400;
    localparam logic [15:0]       BITDIV_RESET = 16'h1000;

    // Settling interval slots
    localparam logic [2:0] W_OS  = 3'h0;
    localparam logic [2:0] W_BBR = 3'h1;
    localparam logic [2:0] W_FS  = 3'h2;
    localparam logic [2:0] W_BB2 = 3'h3;
    localparam logic [2:0] W_TR  = 3'h4;

    typedef enum logic [1:0] {SEQ_RX, SEQ_TX, SEQ_STBY, SEQ_SLEEP} seq_kind_t;
endpackage

// File: core/xcvr_if.sv
// Pin-level link between the host controller and the transceiver
`timescale 1ns/1ps
interface xcvr_if;
    logic [2:0] mode;
    logic       mode_strobe_n;
    logic       tx_modulation_input;
    logic       rx_bit_output;
    logic       recovered_bit_clock;
    logic       match_n;
    logic       ref_clk_out;

    modport dev (
        input  mode,
        input  mode_strobe_n,
        input  tx_modulation_input,
        output rx_bit_output,
        output recovered_bit_clock,
        output match_n,
        output ref_clk_out
    );
    modport host (
        output mode,
        output mode_strobe_n,
        output tx_modulation_input,
        input  rx_bit_output,
        input  recovered_bit_clock,
        input  match_n,
        input  ref_clk_out
    );
endinterface

// File: core/xcvr_device.sv
// Transceiver end: mode latch, data paths, pattern match and clock output
//
// How it works
// - Decode sleep, standby, receive, transmit mode codes.
// - Decode intermediate bring-up codes 010, 011, 110.
// - Host steps receive bring-up with settling waits.
// - Host steps transmit bring-up from standby, stays in transmit.
// - Modulation input passes unsampled in transmit.
// - Host keeps bit rate within five percent.
// - Bit sync on: recovered data plus clock.
// - Bit sync off: raw data, clock low.
// - Match output updates on bit clock rise.
// - Pattern disabled holds match output negated.
// - Clock output at four selectable rates.
// - Clock output stopped in sleep or disabled.
// - Reset clears all configuration to zero.
// - Reset: standby, clock output divided by 32.
// - First strobe rise applies mode, honours enable.
// - Host sets enable, mode bit zero first.
// - Mode changes only while strobe low.
`timescale 1ns/1ps
module xcvr_device #(
    parameter int unsigned BIT_CYCLES = xcvr_pkg::BIT_CYCLES_DEF
) (
    input  wire logic                     ref_clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     clk_en_i,
    xcvr_if.dev                           link,
    input  wire logic                     cfg_we_i,
    input  wire logic [xcvr_pkg::CFG_W-1:0] cfg_ctrl_i,
    input  wire logic [31:0]              cfg_pattern_i,
    input  wire logic                     demod_i,
    output logic [xcvr_pkg::CFG_W-1:0]    cfg_ctrl_o,
    output logic [31:0]                   cfg_pattern_o,
    output logic [2:0]                    mode_o,
    output logic                          osc_en_o,
    output logic                          baseband_en_o,
    output logic                          synth_en_o,
    output logic                          rx_en_o,
    output logic                          tx_en_o,
    output logic                          modulator_o
);
    import xcvr_pkg::*;

    localparam int unsigned HALF = BIT_CYCLES / 2;
    localparam int unsigned CW   = $clog2(BIT_CYCLES + 1);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Enables as {osc, baseband, synth, rx, tx}
    function automatic logic [4:0] mode_enables(input logic [2:0] m);
        logic [4:0] e;
        e = 5'h00;
        unique case (m)
            MODE_SLEEP:    e = 5'h00;
            MODE_STANDBY:  e = 5'h10;
            MODE_RX_BB:    e = 5'h18;
            MODE_RX_SYNTH: e = 5'h1C;
            MODE_RX:       e = 5'h1E;
            MODE_TX_SYNTH: e = 5'h14;
            MODE_TX:       e = 5'h15;
            default:       e = 5'h00; // 101 is undefined, keep all off
        endcase
        return e;
    endfunction

    // Pattern length code selects 8, 16, 24 or 32 bits
    function automatic logic [31:0] pat_mask(input logic [1:0] len);
        logic [31:0] m;
        m = 32'hFFFF_FFFF >> (5'(24) - {len, 3'h0});
        return m;
    endfunction

    // Reference pattern starts at the MSB byte, so shift it down
    function automatic logic [31:0] pat_ref(input logic [31:0] p, input logic [1:0] len);
        logic [31:0] r;
        r = p >> (5'(24) - {len, 3'h0});
        return r;
    endfunction

    // ------------------------------------------------------------
    // Configuration and mode latch
    // ------------------------------------------------------------
    logic [CFG_W-1:0] cfg_r;
    logic [31:0]      pat_r;
    logic [2:0]       mode_r;
    logic             strobe_prev_r;
    logic             first_r;
    logic             strobe_rise;
    logic [4:0]       en;

    assign strobe_rise = link.mode_strobe_n & ~strobe_prev_r;
    assign en          = mode_enables(mode_r);

    // Configuration comes up all zero
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_r <= CFG_RESET;
            pat_r <= PAT_RESET;
        end else if (clk_en_i && cfg_we_i) begin
            cfg_r <= cfg_ctrl_i;
            pat_r <= cfg_pattern_i;
        end
    end

    // Mode pins are only looked at on the strobe rise
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_r        <= MODE_STANDBY;
            strobe_prev_r <= 1'b1;
            first_r       <= 1'b1;
        end else if (clk_en_i) begin
            strobe_prev_r <= link.mode_strobe_n;
            if (strobe_rise) begin
                mode_r  <= link.mode;
                first_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Reference clock output divider
    // ------------------------------------------------------------
    logic [4:0] div_r;
    logic       clk_out_r;
    logic       clk_on;
    logic [1:0] clk_sel;

    assign clk_sel = cfg_r[CFG_CLKSEL +: 2];
    // Power-up keeps the clock alive until the first strobe rise
    assign clk_on  = (mode_r != MODE_SLEEP) && (first_r || cfg_r[CFG_CLKO_EN]);

    // Free-running divider; select 0 taps /32, then /16, /8, /4
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_r     <= 5'h00;
            clk_out_r <= 1'b0;
        end else if (clk_en_i) begin
            div_r     <= div_r + 5'h01;
            clk_out_r <= clk_on & div_r[3'h4 - {1'b0, clk_sel}];
        end
    end

    // ------------------------------------------------------------
    // Receive bit synchroniser
    // ------------------------------------------------------------
    logic          demod_prev_r;
    logic [CW-1:0] cnt_r;
    logic          bclk_r;
    logic          rx_bit_r;
    logic [31:0]   shift_r;
    logic          match_n_r;
    logic          sync_on;
    logic          sample;
    logic          bclk_rise;

    assign sync_on   = en[1] & cfg_r[CFG_BITSYNC];
    // Data change on the falling half so it is stable at the rise
    assign sample    = sync_on && (cnt_r == CW'(HALF));
    assign bclk_rise = sync_on && (cnt_r < CW'(HALF)) && !bclk_r;

    // Phase counter restarts on each demodulator transition
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            demod_prev_r <= 1'b0;
            cnt_r        <= '0;
        end else if (clk_en_i) begin
            demod_prev_r <= demod_i;
            if (!sync_on || (demod_i != demod_prev_r) || (cnt_r == CW'(BIT_CYCLES - 1))) begin
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + CW'(1);
            end
        end
    end

    // Clock high in first half of each bit, low when not syncing
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bclk_r <= 1'b0;
        end else if (clk_en_i) begin
            bclk_r <= sync_on && (cnt_r < CW'(HALF));
        end
    end

    // Data output: resampled stream, or raw demodulator when sync is off
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_bit_r <= 1'b0;
            shift_r  <= 32'h0000_0000;
        end else if (clk_en_i) begin
            if (!en[1]) begin
                rx_bit_r <= 1'b0;
            end else if (!cfg_r[CFG_BITSYNC]) begin
                rx_bit_r <= demod_i;
            end else if (sample) begin
                rx_bit_r <= demod_i;
                shift_r  <= {shift_r[30:0], demod_i};
            end
        end
    end

    // ------------------------------------------------------------
    // Pattern comparator
    // ------------------------------------------------------------
    // Updated only on bit clock rise while the pattern is enabled, so a match lasts one bit
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            match_n_r <= 1'b1;
        end else if (clk_en_i) begin
            if (!cfg_r[CFG_PAT_EN]) begin
                match_n_r <= 1'b1;
            end else if (bclk_rise) begin
                match_n_r <= ((shift_r & pat_mask(cfg_r[CFG_PATLEN +: 2]))
                              != pat_ref(pat_r, cfg_r[CFG_PATLEN +: 2]));
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.rx_bit_output       = rx_bit_r;
    assign link.recovered_bit_clock = bclk_r;
    assign link.match_n             = match_n_r;
    assign link.ref_clk_out         = clk_out_r;
    // Unsampled path; the host owns the bit timing
    assign modulator_o   = en[0] & link.tx_modulation_input;
    assign cfg_ctrl_o    = cfg_r;
    assign cfg_pattern_o = pat_r;
    assign mode_o        = mode_r;
    assign osc_en_o      = en[4];
    assign baseband_en_o = en[3];
    assign synth_en_o    = en[2];
    assign rx_en_o       = en[1];
    assign tx_en_o       = en[0];
endmodule

// File: core/xcvr_host.sv
// Host end: mode sequencer, transmit serialiser and register port
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module xcvr_host (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        clk_en_i,
    xcvr_if.host             link,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        we_i,
    input  wire logic        re_i,
    output logic [31:0]      rdata_o
);
    import xcvr_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HOLD, ST_SETTLE} state_t;

    // ------------------------------------------------------------
    // Step tables
    // ------------------------------------------------------------
    function automatic logic [2:0] step_mode(input seq_kind_t k, input logic [1:0] s);
        logic [2:0] m;
        m = MODE_STANDBY;
        unique case (k)
            SEQ_RX:    m = (s == 2'h0) ? MODE_STANDBY : (s == 2'h1) ? MODE_RX_BB :
                           (s == 2'h2) ? MODE_RX_SYNTH : MODE_RX;
            SEQ_TX:    m = (s == 2'h0) ? MODE_STANDBY : (s == 2'h1) ? MODE_TX_SYNTH : MODE_TX;
            SEQ_STBY:  m = MODE_STANDBY;
            SEQ_SLEEP: m = MODE_SLEEP;
        endcase
        return m;
    endfunction

    function automatic logic [2:0] step_wait(input seq_kind_t k, input logic [1:0] s);
        logic [2:0] w;
        w = W_OS;
        if (k == SEQ_RX) begin
            w = 3'(s);
        end else if (s != 2'h0) begin
            w = (s == 2'h1) ? W_FS : W_TR;
        end
        return w;
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [WAIT_W-1:0] wait_r [0:4];
    logic [15:0]       bitdiv_r;
    state_t            state_r;
    seq_kind_t         kind_r;
    logic [1:0]        step_r;
    logic [WAIT_W-1:0] cnt_r;
    logic [2:0]        mode_r;
    logic              strobe_n_r;
    logic              rx_ready_r;
    logic              tx_ready_r;
    logic [7:0]        tx_sh_r;
    logic [3:0]        tx_left_r;
    logic [15:0]       tx_cnt_r;
    logic              tx_mod_r;
    logic              bclk_prev_r;
    logic [7:0]        rx_sh_r;
    logic [31:0]       rdata_r;
    logic              last_step;
    logic              go;
    seq_kind_t         go_kind;

    assign last_step = (kind_r == SEQ_RX) ? (step_r == 2'h3) :
                       (kind_r == SEQ_TX) ? (step_r == 2'h2) : 1'b1;
    assign go = we_i && (addr_i == REG_CTRL) && (state_r == ST_IDLE) && (wdata_i[3:0] != 4'h0);
    assign go_kind = wdata_i[CTRL_GO_RX] ? SEQ_RX : wdata_i[CTRL_GO_TX] ? SEQ_TX :
                     wdata_i[CTRL_GO_STBY] ? SEQ_STBY : SEQ_SLEEP;

    // Settling counts and bit period, all software programmable
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < 5; i++) begin
                wait_r[i] <= WAIT_RESET;
            end
            bitdiv_r <= BITDIV_RESET;
        end else if (clk_en_i && we_i) begin
            if (addr_i >= REG_W_OS && addr_i <= REG_W_TR && addr_i[1:0] == 2'h0) begin
                wait_r[3'(addr_i[7:2] - 6'h01)] <= wdata_i[WAIT_W-1:0];
            end
            if (addr_i == REG_BITDIV) begin
                bitdiv_r <= wdata_i[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Mode sequencer: strobe low, set mode, rise, hold, settle
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r    <= ST_IDLE;
            kind_r     <= SEQ_STBY;
            step_r     <= 2'h0;
            cnt_r      <= '0;
            mode_r     <= MODE_STANDBY;
            strobe_n_r <= 1'b1;
            rx_ready_r <= 1'b0;
            tx_ready_r <= 1'b0;
        end else if (clk_en_i) begin
            unique case (state_r)
                ST_IDLE: if (go) begin
                    kind_r     <= go_kind;
                    step_r     <= 2'h0;
                    strobe_n_r <= 1'b0;
                    cnt_r      <= WAIT_W'(STROBE_LOW_CYC);
                    rx_ready_r <= 1'b0;
                    tx_ready_r <= 1'b0;
                    state_r    <= ST_LOW;
                end
                ST_LOW: begin
                    // Mode moves one cycle after the strobe falls
                    if (cnt_r == WAIT_W'(STROBE_LOW_CYC)) begin
                        mode_r <= step_mode(kind_r, step_r);
                    end
                    if (cnt_r == WAIT_W'(1)) begin
                        strobe_n_r <= 1'b1;
                        cnt_r      <= WAIT_W'(MODE_HOLD_CYC);
                        state_r    <= ST_HOLD;
                    end else begin
                        cnt_r <= cnt_r - WAIT_W'(1);
                    end
                end
                ST_HOLD: begin
                    if (cnt_r == WAIT_W'(1)) begin
                        cnt_r   <= wait_r[step_wait(kind_r, step_r)];
                        state_r <= (kind_r == SEQ_STBY || kind_r == SEQ_SLEEP) ? ST_IDLE
                                                                              : ST_SETTLE;
                    end else begin
                        cnt_r <= cnt_r - WAIT_W'(1);
                    end
                end
                ST_SETTLE: begin
                    if (cnt_r != '0) begin
                        cnt_r <= cnt_r - WAIT_W'(1);
                    end else if (last_step) begin
                        rx_ready_r <= (kind_r == SEQ_RX);
                        tx_ready_r <= (kind_r == SEQ_TX);
                        state_r    <= ST_IDLE;
                    end else begin
                        step_r     <= step_r + 2'h1;
                        strobe_n_r <= 1'b0;
                        cnt_r      <= WAIT_W'(STROBE_LOW_CYC);
                        state_r    <= ST_LOW;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Transmit serialiser, MSB first, each bit held one period
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_sh_r   <= 8'h00;
            tx_left_r <= 4'h0;
            tx_cnt_r  <= 16'h0000;
            tx_mod_r  <= 1'b0;
        end else if (clk_en_i) begin
            if (tx_left_r == 4'h0) begin
                tx_mod_r <= 1'b0;
                if (we_i && addr_i == REG_TXDATA && tx_ready_r) begin
                    tx_sh_r   <= {wdata_i[6:0], 1'b0};
                    tx_mod_r  <= wdata_i[7];
                    tx_left_r <= 4'h8;
                    tx_cnt_r  <= bitdiv_r;
                end
            end else if (tx_cnt_r > 16'h0001) begin
                tx_cnt_r <= tx_cnt_r - 16'h0001;
            end else begin
                tx_left_r <= tx_left_r - 4'h1;
                tx_cnt_r  <= bitdiv_r;
                tx_mod_r  <= (tx_left_r == 4'h1) ? 1'b0 : tx_sh_r[7];
                tx_sh_r   <= {tx_sh_r[6:0], 1'b0};
            end
        end
    end

    // Receive bits are taken on the recovered clock rise
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bclk_prev_r <= 1'b0;
            rx_sh_r     <= 8'h00;
        end else if (clk_en_i) begin
            bclk_prev_r <= link.recovered_bit_clock;
            if (link.recovered_bit_clock && !bclk_prev_r) begin
                rx_sh_r <= {rx_sh_r[6:0], link.rx_bit_output};
            end
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (clk_en_i) begin
            rdata_r <= 32'h0000_0000;
            if (re_i) begin
                unique case (addr_i)
                    REG_W_OS:   rdata_r <= 32'(wait_r[W_OS]);
                    REG_W_BBR:  rdata_r <= 32'(wait_r[W_BBR]);
                    REG_W_FS:   rdata_r <= 32'(wait_r[W_FS]);
                    REG_W_BB2:  rdata_r <= 32'(wait_r[W_BB2]);
                    REG_W_TR:   rdata_r <= 32'(wait_r[W_TR]);
                    REG_BITDIV: rdata_r <= {16'h0000, bitdiv_r};
                    REG_STATUS: rdata_r <= {16'h0000, rx_sh_r, ~link.match_n,
                                            (tx_left_r != 4'h0), tx_ready_r, rx_ready_r,
                                            (state_r != ST_IDLE), mode_r};
                    default:    rdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign link.mode                = mode_r;
    assign link.mode_strobe_n       = strobe_n_r;
    assign link.tx_modulation_input = tx_mod_r;
    assign rdata_o                  = rdata_r;
endmodule

// File: testbench/xcvr_link_props.sv
// Checker for the host to transceiver pin link
`timescale 1ns/1ps
module xcvr_link_props (
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    input wire logic [2:0] mode,
    input wire logic       mode_strobe_n,
    input wire logic       rx_bit_output,
    input wire logic       recovered_bit_clock,
    input wire logic       match_n,
    input wire logic       ref_clk_out
);
    logic [2:0] app_r;
    logic [9:0] low_r;
    logic       strb_r;
    logic       seen_r;
    wire        rise = mode_strobe_n & ~strb_r;
    // ------------------------------------------
    // Applied mode, strobe low time, first rise
    // ------------------------------------------
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            app_r <= 3'h1;
            strb_r <= 1'h1;
            low_r <= 10'h000;
            seen_r <= 1'h0;
        end else begin
            strb_r <= mode_strobe_n;
            low_r <= mode_strobe_n ? 10'h000 : low_r + 10'h001; // Host never idles low long
            seen_r <= seen_r | rise;
            if (rise) begin
                app_r <= mode;
            end
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    sequence step_s(logic [2:0] m);
        rise && mode == m;
    endsequence
    rx_order_a: assert property (step_s(3'h4) |-> app_r == 3'h3)
        else $error("rx step order");
    tx_order_a: assert property (step_s(3'h7) |-> app_r == 3'h6)
        else $error("tx step order");
    mode_hold_a: assert property ($changed(mode) |-> !mode_strobe_n)
        else $error("mode moved high");
    strobe_width_a: assert property (rise |-> low_r >= 10'h190)
        else $error("strobe too short");
    sleep_clk_a: assert property ((app_r == 3'h0) [*6] |-> !ref_clk_out)
        else $error("clock in sleep");
    rx_idle_a: assert property ((app_r != 3'h4) [*6] |-> !rx_bit_output && !recovered_bit_clock)
        else $error("rx out idle");
    ref_div_a: assert property (!seen_r && mode_strobe_n && $rose(ref_clk_out)
        |-> ##15 ref_clk_out ##1 !ref_clk_out) else $error("clock not div32");
    match_edge_a: assert property ($fell(match_n) |-> $rose(recovered_bit_clock))
        else $error("match off edge");
endmodule

// File: testbench/transceiver_mode_and_data_io_tb_top.sv
// Bench joining host and transceiver ends through the pin link
`timescale 1ns/1ps
module transceiver_mode_and_data_io_tb_top;
    import xcvr_pkg::*;
    localparam logic [7:0] SYNC = 8'hA5;
    logic clk, rst, we, re, cwe, dm, osc, bb, syn, rxe, txe, modo;
    logic [7:0] addr;
    logic [31:0] wd, rdata, v, po;
    logic [6:0] cfg, cfg_o;
    logic [2:0] mode_o;
    int fail_count, tests_run, cyc;
    xcvr_if link ();
    xcvr_host xcvr_host_inst (.ref_clk_i(clk), .rst_i(rst), .clk_en_i(1'h1), .link(link),
        .addr_i(addr), .wdata_i(wd), .we_i(we), .re_i(re), .rdata_o(rdata));
    xcvr_device #(.BIT_CYCLES(16)) xcvr_device_inst (.ref_clk_i(clk), .rst_i(rst),
        .clk_en_i(1'h1), .link(link), .cfg_we_i(cwe), .cfg_ctrl_i(cfg),
        .cfg_pattern_i({SYNC, 24'h000000}), .demod_i(dm), .cfg_ctrl_o(cfg_o),
        .cfg_pattern_o(po), .mode_o(mode_o), .osc_en_o(osc), .baseband_en_o(bb),
        .synth_en_o(syn), .rx_en_o(rxe), .tx_en_o(txe), .modulator_o(modo));
    xcvr_link_props xcvr_link_props_inst (.ref_clk_i(clk), .rst_i(rst), .mode(link.mode),
        .mode_strobe_n(link.mode_strobe_n), .rx_bit_output(link.rx_bit_output),
        .recovered_bit_clock(link.recovered_bit_clock), .match_n(link.match_n),
        .ref_clk_out(link.ref_clk_out));
    task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask
    // Strobes drop at the next edge, so back to back calls leave one idle cycle
    task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        we <= w;
        re <= !w;
        @(posedge clk);
        we <= 1'h0;
        re <= 1'h0;
        #1 v = rdata;
    endtask
    task automatic go(int b, logic [4:0] en);
        acc(1'h1, REG_CTRL, 32'h1 << b);
        repeat (3) @(posedge clk);
        do acc(1'h0, REG_STATUS, 32'h0); while (v[3] === 1'h1);
        chk("enables", {osc, bb, syn, rxe, txe}, en);
    endtask
    task automatic setcfg(logic [6:0] c);
        @(posedge clk);
        cwe <= 1'h1;
        cfg <= c;
        @(posedge clk);
        cwe <= 1'h0;
    endtask
    task automatic complete_run;
        if (fail_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    // Hang guard, well above the few thousand cycles needed
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        {rst, we, re, cwe, dm, addr, wd, cfg, fail_count, tests_run, cyc} = '0;
        rst = 1'h1;
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        #1 chk("mode", mode_o, MODE_STANDBY);
        chk("cfg", cfg_o, CFG_RESET);
        chk("pattern", po, PAT_RESET);
        chk("match", link.match_n, 1'h1);
        acc(1'h0, 8'h3C, 32'h0);
        chk("unmapped", v, 32'h0);
        for (int i = 1; i <= 5; i++) acc(1'h1, 8'(4 * i), 32'h10);
        acc(1'h1, REG_BITDIV, 32'h8);
        setcfg(7'h07);
        go(CTRL_GO_RX, 5'h1E);
        @(posedge clk);
        for (int i = 7; i >= 0; i--) begin
            dm <= SYNC[i];
            repeat (16) @(posedge clk);
        end
        repeat (8) @(posedge clk);
        #1 chk("match", link.match_n, 1'h0);
        chk("rx data", link.rx_bit_output, SYNC[0]);
        acc(1'h0, REG_STATUS, 32'h0);
        chk("status", v[15:0], {SYNC, 8'h94});
        setcfg(7'h05);
        repeat (2) @(posedge clk);
        #1 chk("match off", link.match_n, 1'h1);
        go(CTRL_GO_TX, 5'h15);
        acc(1'h1, REG_TXDATA, {24'h0, SYNC});
        repeat (2) @(posedge clk);
        for (int i = 7; i >= 0; i--) begin
            #1 chk("modulator", modo, SYNC[i]);
            repeat (8) @(posedge clk);
        end
        go(CTRL_GO_SLEEP, 5'h00);
        chk("clock out", link.ref_clk_out, 1'h0);
        complete_run();
    end
endmodule
